// >>> design/isoch_desc_defs.svh
// Offsets, field positions, limits and reset values of the descriptor decoder
`ifndef ISOCH_DESC_DEFS_SVH
`define ISOCH_DESC_DEFS_SVH

`define ADDR_W           8
`define OFF_DESC0        8'h00
`define OFF_DESC1        8'h04
`define OFF_DESC2        8'h08
`define OFF_DESC3        8'h0C
`define OFF_CTRL         8'h10
`define OFF_STATUS       8'h14
`define OFF_FIELDS       8'h18

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`define LEN_MSB          16
`define LEN_LSB          0
`define SIZE_MSB         21
`define SIZE_LSB         17
`define INTR_MSB         31
`define INTR_LSB         22
`define INLINE_BIT       6
`define LBPC_MSB         19
`define LBPC_LSB         16

`define XFER_LEN_MAX     17'h10000
`define INLINE_LEN_MAX   17'h00008
`define LEN_ZERO         17'h00000

`define CTRL_EXT_BIT     0
`define CTRL_DECODE_BIT  1
`define CTRL_DIR_IN_BIT  2
`define CTRL_ICNT_MSB    14
`define CTRL_ICNT_LSB    4
`define CTRL_BSEL_MSB    20
`define CTRL_BSEL_LSB    16
`define CTRL_MBS_MSB     28
`define CTRL_MBS_LSB     24
`define CTRL_RESET       32'h0100_0010

`define STATUS_PAD_W     21
`define STATUS_PAD       21'h000000

`endif

// >>> design/isoch_desc_pkg.sv
// Types shared by the descriptor decoder
package isoch_desc_pkg;

  typedef struct packed {
    logic                    aw_got;
    logic [7:0]              aw_addr;
    logic                    w_got;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    aw_ready;
    logic                    w_ready;
    logic                    b_valid;
    logic [1:0]              b_resp;
    logic                    ar_ready;
    logic                    r_valid;
    logic [1:0]              r_resp;
    logic [31:0]             r_data;
    logic [3:0][31:0]        desc;
    logic [31:0]             ctrl;
    logic [63:0]             pointer;
    logic                    pointer_is_data;
    logic [16:0]             send_bytes;
    logic [16:0]             expect_bytes;
    logic [4:0]              remaining;
    logic [4:0]              bursts;
    logic [3:0]              last_pkts;
    logic [9:0]              intr;
    logic                    len_err;
    logic                    intr_err;
    logic                    decoded;
    logic                    decode_valid;
  } decoder_state_t;

endpackage

// >>> design/burst_packet_planner.sv
// Packet count of one selected burst of an isochronous descriptor
`include "isoch_desc_defs.svh"

module burst_packet_planner
  import isoch_desc_pkg::*;
#(
  parameter int COUNT_W = 5
)
(
  input  wire logic [COUNT_W-1:0] burst_index,
  input  wire logic [COUNT_W-1:0] burst_count_minus_one,
  input  wire logic [COUNT_W-1:0] max_burst_size,
  input  wire logic [3:0]         last_burst_packet_count,
  output logic      [COUNT_W-1:0] burst_packets,
  output logic                    burst_is_last,
  output logic                    burst_in_range
);

  always_comb
  begin
    burst_in_range = (burst_index <= burst_count_minus_one);
    burst_is_last  = (burst_index == burst_count_minus_one);
    // RQ9 last burst differs
    if (!burst_in_range)
    begin
      burst_packets = '0;
    end
    else if (burst_is_last)
    begin
      burst_packets = COUNT_W'({1'b0, last_burst_packet_count} + 5'h01);
    end
    else
    begin
      burst_packets = max_burst_size;
    end
  end

endmodule

// >>> design/isoch_descriptor_field_decoder.sv
// AXI4-Lite reachable decoder of the first isochronous descriptor doublewords
//
// Behaviour
// RQ1 - Join doublewords zero and one into 64 bits
// RQ2 - Inline flag picks address or literal data
// RQ3 - Any byte alignment of buffer address accepted
// RQ4 - Outbound: length field is bytes sent
// RQ5 - Inbound: length field is bytes expected
// RQ6 - Software keeps length within zero to 64K
// RQ7 - Extended off: field is remaining size hint
// RQ8 - Extended on: field is bursts minus one
// RQ9 - Full bursts max size; last uses count+1
// RQ10 - Bits 31:22 select the event interrupter
// RQ11 - Software keeps interrupter below implemented count
// RQ12 - Inline payload length at most eight bytes
// RQ13 - Present fields in parallel, flag range faults
`include "isoch_desc_defs.svh"

module isoch_descriptor_field_decoder
  import isoch_desc_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                clk_en,
  input  wire logic [`ADDR_W-1:0]  awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [`ADDR_W-1:0]  araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  output logic [63:0]              buffer_pointer,
  output logic                     inline_payload_flag,
  output logic [16:0]              send_byte_count,
  output logic [16:0]              expect_byte_count,
  output logic [4:0]               remaining_size_hint,
  output logic [4:0]               burst_count_minus_one,
  output logic [3:0]               last_burst_packet_count,
  output logic [9:0]               interrupter_index,
  output logic                     length_error,
  output logic                     interrupter_error,
  output logic                     decode_valid
);

  decoder_state_t s;
  decoder_state_t next_s;
  logic [4:0]     plan_packets;
  logic           plan_last;
  logic           plan_in_range;
  logic [31:0]    merged;
  logic [16:0]    len;
  logic [10:0]    icnt;

  function automatic logic [31:0] apply_strobe(input logic [31:0] old_word,
                                                input logic [31:0] new_word,
                                                input logic [3:0]  strb);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // RQ12 inline length limit
  function automatic logic length_out_of_range(input logic [16:0] length,
                                               input logic        inline_data);
    return inline_data ? (length > `INLINE_LEN_MAX) : (length > `XFER_LEN_MAX);
  endfunction

  burst_packet_planner #(
    .COUNT_W (5)
  ) planner (
    .burst_index             (s.ctrl[`CTRL_BSEL_MSB:`CTRL_BSEL_LSB]),
    .burst_count_minus_one   (s.bursts),
    .max_burst_size          (s.ctrl[`CTRL_MBS_MSB:`CTRL_MBS_LSB]),
    .last_burst_packet_count (s.last_pkts),
    .burst_packets           (plan_packets),
    .burst_is_last           (plan_last),
    .burst_in_range          (plan_in_range)
  );

  always_comb
  begin
    next_s = s;
    merged = '0;
    next_s.decode_valid = 1'b0;

    // Address and data may arrive in either order
    if (awvalid && s.aw_ready)
    begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && s.w_ready)
    begin
      next_s.w_got  = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (bready && s.b_valid)
    begin
      next_s.b_valid = 1'b0;
    end

    if (s.aw_got && s.w_got && !s.b_valid)
    begin
      next_s.aw_got  = 1'b0;
      next_s.w_got   = 1'b0;
      next_s.b_valid = 1'b1;
      next_s.b_resp  = `RESP_OKAY;
      case (s.aw_addr)
        `OFF_DESC0: next_s.desc[0] = apply_strobe(s.desc[0], s.w_data, s.w_strb);
        `OFF_DESC1: next_s.desc[1] = apply_strobe(s.desc[1], s.w_data, s.w_strb);
        `OFF_DESC2: next_s.desc[2] = apply_strobe(s.desc[2], s.w_data, s.w_strb);
        `OFF_DESC3: next_s.desc[3] = apply_strobe(s.desc[3], s.w_data, s.w_strb);
        `OFF_CTRL:
        begin
          merged = apply_strobe(s.ctrl, s.w_data, s.w_strb);
          next_s.ctrl = merged;
          // Decode request is a strobe, never stored
          next_s.ctrl[`CTRL_DECODE_BIT] = 1'b0;
        end
        default: next_s.b_resp = `RESP_SLVERR;
      endcase
    end
    next_s.aw_ready = !next_s.aw_got && !next_s.b_valid;
    next_s.w_ready  = !next_s.w_got && !next_s.b_valid;

    // RQ13 capture all fields together
    len  = s.desc[2][`LEN_MSB:`LEN_LSB];
    icnt = next_s.ctrl[`CTRL_ICNT_MSB:`CTRL_ICNT_LSB];
    if (merged[`CTRL_DECODE_BIT])
    begin
      next_s.decoded      = 1'b1;
      next_s.decode_valid = 1'b1;
      // RQ1 pointer from two doublewords
      next_s.pointer = {s.desc[1], s.desc[0]};
      // RQ2 inline flag qualifies pointer
      next_s.pointer_is_data = s.desc[3][`INLINE_BIT];
      // RQ3 no alignment check
      // RQ4 outbound byte count
      next_s.send_bytes   = next_s.ctrl[`CTRL_DIR_IN_BIT] ? `LEN_ZERO : len;
      // RQ5 inbound expected count
      next_s.expect_bytes = next_s.ctrl[`CTRL_DIR_IN_BIT] ? len : `LEN_ZERO;
      if (next_s.ctrl[`CTRL_EXT_BIT])
      begin
        // RQ8 burst count view
        next_s.bursts    = s.desc[2][`SIZE_MSB:`SIZE_LSB];
        next_s.remaining = '0;
      end
      else
      begin
        // RQ7 remaining size view
        next_s.remaining = s.desc[2][`SIZE_MSB:`SIZE_LSB];
        next_s.bursts    = '0;
      end
      // RQ9 last burst packet field
      next_s.last_pkts = s.desc[3][`LBPC_MSB:`LBPC_LSB];
      // RQ10 interrupter index extract
      next_s.intr = s.desc[2][`INTR_MSB:`INTR_LSB];
      // RQ6 length range flagged
      next_s.len_err = length_out_of_range(len, s.desc[3][`INLINE_BIT]);
      // RQ11 interrupter range flagged
      next_s.intr_err = ({1'b0, s.desc[2][`INTR_MSB:`INTR_LSB]} >= icnt);
    end

    // Read channel, one outstanding read
    if (arvalid && s.ar_ready)
    begin
      next_s.r_valid = 1'b1;
      next_s.r_resp  = `RESP_OKAY;
      case (araddr)
        `OFF_DESC0:  next_s.r_data = s.desc[0];
        `OFF_DESC1:  next_s.r_data = s.desc[1];
        `OFF_DESC2:  next_s.r_data = s.desc[2];
        `OFF_DESC3:  next_s.r_data = s.desc[3];
        `OFF_CTRL:   next_s.r_data = s.ctrl;
        `OFF_STATUS: next_s.r_data = {`STATUS_PAD, plan_in_range, plan_last, plan_packets,
                                      s.pointer_is_data, s.intr_err, s.len_err, s.decoded};
        // One of each pair is zero, so OR shows the live view
        `OFF_FIELDS: next_s.r_data = {s.intr, s.bursts | s.remaining,
                                      s.send_bytes | s.expect_bytes};
        default:
        begin
          next_s.r_data = '0;
          next_s.r_resp = `RESP_SLVERR;
        end
      endcase
    end
    else if (rready && s.r_valid)
    begin
      next_s.r_valid = 1'b0;
    end
    next_s.ar_ready = !next_s.r_valid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s      <= '0;
      s.ctrl <= `CTRL_RESET;
    end
    else if (clk_en)
    begin
      s <= next_s;
    end
  end

  assign awready                 = s.aw_ready;
  assign wready                  = s.w_ready;
  assign bvalid                  = s.b_valid;
  assign bresp                   = s.b_resp;
  assign arready                 = s.ar_ready;
  assign rvalid                  = s.r_valid;
  assign rresp                   = s.r_resp;
  assign rdata                   = s.r_data;
  assign buffer_pointer          = s.pointer;
  assign inline_payload_flag     = s.pointer_is_data;
  assign send_byte_count         = s.send_bytes;
  assign expect_byte_count       = s.expect_bytes;
  assign remaining_size_hint     = s.remaining;
  assign burst_count_minus_one   = s.bursts;
  assign last_burst_packet_count = s.last_pkts;
  assign interrupter_index       = s.intr;
  assign length_error            = s.len_err;
  assign interrupter_error       = s.intr_err;
  assign decode_valid            = s.decode_valid;

endmodule

// >>> tb/host_desc_ring.sv
// Host software model: descriptor words as laid out in the ring
module host_desc_ring
(
  input  wire logic             sel,
  output logic      [3:0][31:0] desc
);
  timeunit 1ns;
  timeprecision 1ns;
  always_comb
  begin
    if (!sel)
      desc = {32'h0002_0000, 32'h0147_0000, 32'hABCD_0001, 32'h1234_5673};
    else
      // Deliberate breach: inline length 9, index 8
      desc = {32'h0002_0040, 32'h0204_0009, 32'h0403_0201, 32'h0807_0605};
  end
endmodule

// >>> tb/isoch_desc_decoder_asserts.sv
// Port-level checker for the descriptor decoder
`include "isoch_desc_defs.svh"
module desc_decoder_chk
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        bvalid,
  input wire logic        rvalid,
  input wire logic [63:0] buffer_pointer,
  input wire logic [16:0] send_byte_count,
  input wire logic [16:0] expect_byte_count,
  input wire logic [4:0]  remaining_size_hint,
  input wire logic [4:0]  burst_count_minus_one,
  input wire logic        inline_payload_flag,
  input wire logic        length_error,
  input wire logic        decode_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // One side is zero, so the OR is the length field
  logic [16:0] len;
  assign len = send_byte_count | expect_byte_count;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Nothing is taken on a frozen edge
  sequence aw_taken;
    awvalid && awready && clk_en;
  endsequence
  sequence ar_taken;
    arvalid && arready && clk_en;
  endsequence
  wr_answer_a: assert property (aw_taken |-> ##[1:3] bvalid)
    else $error("write response missing");
  rd_answer_a: assert property (ar_taken |-> ##[1:2] rvalid)
    else $error("read data missing");
  pulse_once_a: assert property (decode_valid |=> !decode_valid)
    else $error("decode pulse too long");
  decode_resp_a: assert property (decode_valid |-> bvalid)
    else $error("decode without response");
  dir_split_a: assert property (decode_valid |-> !(send_byte_count && expect_byte_count))
    else $error("both directions loaded");
  size_split_a: assert property (decode_valid |-> !(remaining_size_hint && burst_count_minus_one))
    else $error("size and bursts both loaded");
  hold_fields_a: assert property (!decode_valid |-> $stable(buffer_pointer) && $stable(len))
    else $error("fields moved without decode");
  len_flag_a: assert property (decode_valid |-> length_error == (len > `XFER_LEN_MAX
    || (inline_payload_flag && len > `INLINE_LEN_MAX)))
    else $error("length flag wrong");
endmodule

bind isoch_descriptor_field_decoder desc_decoder_chk u_chk (.aclk, .aresetn, .clk_en, .awvalid,
  .awready,
  .arvalid, .arready, .bvalid, .rvalid, .buffer_pointer, .send_byte_count, .expect_byte_count,
  .remaining_size_hint, .burst_count_minus_one, .inline_payload_flag, .length_error, .decode_valid);

// >>> tb/tb_isoch_descriptor_field_decoder.sv
// Self-checking bench for the descriptor field decoder
`include "isoch_desc_defs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_isoch_descriptor_field_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic             aclk, aresetn, clk_en, awvalid, awready, wvalid, wready, bvalid, bready;
  logic             arvalid, arready, rvalid, rready, inline_payload_flag, length_error;
  logic             interrupter_error, decode_valid, host_sel;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, rdata, d;
  logic [3:0]       wstrb, last_burst_packet_count;
  logic [1:0]       bresp, rresp, r;
  logic [63:0]      buffer_pointer;
  logic [16:0]      send_byte_count, expect_byte_count;
  logic [4:0]       remaining_size_hint, burst_count_minus_one;
  logic [9:0]       interrupter_index;
  logic [3:0][31:0] host_desc;
  int               n_errors = 0;
  int               checked = 0;

  isoch_descriptor_field_decoder dut (.aclk, .aresetn, .clk_en, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .buffer_pointer, .inline_payload_flag, .send_byte_count,
    .expect_byte_count, .remaining_size_hint, .burst_count_minus_one, .last_burst_packet_count,
    .interrupter_index, .length_error, .interrupter_error, .decode_valid);
  host_desc_ring u_host (.sel(host_sel), .desc(host_desc));

  initial
  begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  // Max burst size fixed at 4, decode strobe always set
  function automatic logic [31:0] ctrl(logic [4:0] bsel, logic [10:0] cnt, logic dir, logic ext);
    return {8'h04, 3'h0, bsel, 1'h0, cnt, 1'h0, dir, 1'h1, ext};
  endfunction

  // Ready lines stay high, so the answer edge is the handshake edge
  // Only enabled edges move items; the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready && clk_en) awvalid <= 1'h0;
      if (wready && clk_en) wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1 || !clk_en);
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arready && clk_en) arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1 || !clk_en);
    r = rresp;
    d = rdata;
  endtask

  task automatic load(input logic s);
    host_sel <= s;
    @(posedge aclk);
    for (int i = 0; i < 4; i++)
      wr(`OFF_DESC0 + 8'(4 * i), host_desc[i]);
  endtask

  task automatic t_reset;
    rd(`OFF_CTRL);
    `CHK("ctrl", `CTRL_RESET, d)
    `CHK("pointer", 64'h0, buffer_pointer)
  endtask

  task automatic t_outbound;
    load(1'h0);
    wr(`OFF_CTRL, ctrl(5'h00, 11'h008, 1'h0, 1'h0));
    `CHK("bresp", `RESP_OKAY, r)
    `CHK("pointer", 64'hABCD_0001_1234_5673, buffer_pointer)
    `CHK("inline", 1'h0, inline_payload_flag)
    `CHK("send", 17'h10000, send_byte_count)
    `CHK("expect", 17'h00000, expect_byte_count)
    `CHK("size", 5'h03, remaining_size_hint)
    `CHK("bursts", 5'h00, burst_count_minus_one)
    `CHK("intr", 10'h005, interrupter_index)
    `CHK("errs", 2'h0, {length_error, interrupter_error})
    `CHK("lbpc", 4'h2, last_burst_packet_count)
  endtask

  task automatic t_inbound;
    logic [4:0]  bsel [3] = '{5'h02, 5'h01, 5'h03};
    logic [31:0] st [3] = '{32'h0000_063F, 32'h0000_044F, 32'h0000_000F};
    load(1'h1);
    for (int k = 0; k < 3; k++)
    begin
      wr(`OFF_CTRL, ctrl(bsel[k], 11'h008, 1'h1, 1'h1));
      rd(`OFF_STATUS);
      `CHK("status", st[k], d)
    end
    `CHK("pointer", 64'h0403_0201_0807_0605, buffer_pointer)
    `CHK("inline", 1'h1, inline_payload_flag)
    `CHK("expect", 17'h00009, expect_byte_count)
    `CHK("send", 17'h00000, send_byte_count)
    `CHK("bursts", 5'h02, burst_count_minus_one)
    `CHK("size", 5'h00, remaining_size_hint)
    `CHK("intr", 10'h008, interrupter_index)
    `CHK("errs", 2'h3, {length_error, interrupter_error})
  endtask

  task automatic t_bus;
    wr(`OFF_STATUS, 32'hFFFF_FFFF);
    `CHK("bresp", `RESP_SLVERR, r)
    rd(8'h1C);
    `CHK("rresp", `RESP_SLVERR, r)
    `CHK("rdata", 32'h0, d)
    rd(`OFF_CTRL);
    `CHK("ctrl", ctrl(5'h03, 11'h008, 1'h1, 1'h1) & 32'hFFFF_FFFD, d)
  endtask

  // Byte strobe merge, then a decode held off by the enable
  task automatic t_freeze;
    wstrb <= 4'h1;
    wr(`OFF_DESC0, 32'hFFFF_FFFF);
    wstrb <= 4'hF;
    clk_en <= 1'h0;
    fork
      wr(`OFF_CTRL, ctrl(5'h00, 11'h008, 1'h0, 1'h0));
      begin
        repeat (3) @(posedge aclk);
        `CHK("frozen bvalid", 1'h0, bvalid)
        `CHK("frozen ready", 2'h3, {awready, wready})
        `CHK("frozen pointer", 64'h0403_0201_0807_0605, buffer_pointer)
        clk_en <= 1'h1;
      end
    join
    `CHK("pulse", 1'h1, decode_valid)
    `CHK("thawed pointer", 64'h0403_0201_0807_06FF, buffer_pointer)
    `CHK("thawed send", 17'h00009, send_byte_count)
    `CHK("thawed size", 5'h02, remaining_size_hint)
    @(posedge aclk);
    `CHK("pulse end", 1'h0, decode_valid)
  endtask

  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    aresetn = 1'h0;
    clk_en = 1'h1;
    bready = 1'h1;
    rready = 1'h1;
    awvalid = 1'h0;
    wvalid = 1'h0;
    arvalid = 1'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    host_sel = 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset;
    t_outbound;
    t_inbound;
    t_bus;
    t_freeze;
    close_out;
  end

  // Whole run is under a hundred cycles
  initial
  begin
    #100000;
    n_errors++;
    close_out;
  end
endmodule
